// [shared/uamp_pkg.sv]
// Package for the multiprocessor address-match receiver: register indices, fields, reset values, states.
// Assumes an APB slave whose register byte address is four times the register index.
// Overview of operation
// - Nine-bit modes with multiprocessor on flag only bytes matching given or broadcast address.
// - With multiprocessor off, every complete frame received while the flag is clear sets the receive-done flag.
// - Ten-bit mode with multiprocessor on needs stop bit one and an address match.
// - Address compare is hardware, so unaddressed slaves see no receive-done flag activity.
// - An 8-bit software-programmable match value holds the slave's own address.
// - Given address compares only bit positions where the mask holds one.
// - Broadcast address is match OR mask; its zero bits are don't-care.
// - Match value sits at index A9h, mask at index B9h.
// - Reset clears match and mask to 00h, so every address is accepted.
// - The received ninth bit of each frame that loads the buffer is kept in its own status bit.
// - Frames start being received only while receive enable is high.
// - Buffer load and flag set need flag clear and multiprocessor off or ninth bit one (the stop bit in ten-bit mode).
package uamp_pkg;

  localparam int unsigned IDX_W = 10;
  localparam int unsigned ADDR_W = 12;

  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h000;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h001;
  localparam logic [IDX_W-1:0] IDX_RXDATA = 10'h002;
  localparam logic [IDX_W-1:0] IDX_BAUD = 10'h003;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h004;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h005;
  localparam logic [IDX_W-1:0] IDX_MATCH = 10'h0a9;
  localparam logic [IDX_W-1:0] IDX_MASK = 10'h0b9;

  // Control fields
  localparam int unsigned CTRL_REN = 0;
  localparam int unsigned CTRL_MPE = 1;
  localparam int unsigned CTRL_MODE_LO = 2;
  localparam int unsigned CTRL_MODE_HI = 3;

  // Status fields
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_NINTH = 1;
  localparam int unsigned ST_FERR = 2;

  // Interrupt fields
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_RX = 0;
  localparam int unsigned IRQ_FE = 1;

  // Serial modes
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_TEN = 2'h1;

  // Oversampling: three votes on slices 7, 8 and 9 of 16
  localparam logic [3:0] OS_VOTE0 = 4'h7;
  localparam logic [3:0] OS_VOTE1 = 4'h8;
  localparam logic [3:0] OS_VOTE2 = 4'h9;
  localparam logic [3:0] BITS_TEN = 4'h8;
  localparam logic [3:0] BITS_ELEVEN = 4'h9;

  localparam logic [7:0] MATCH_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h006c;
  localparam logic [3:0] CTRL_RST = 4'h0;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_BITS  = 4'b0100,
    RX_STOP  = 4'b1000
  } uamp_rx_e;

endpackage

// [design/uamp_addr_match.sv]
// Address recognition: given and broadcast hits for a received byte.
// Assumes match value and mask come straight from software registers.
`timescale 1ns/1ps
`default_nettype none
module uamp_addr_match #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] rx_byte,
  input  wire logic [W-1:0] match_value,
  input  wire logic [W-1:0] match_mask,
  output logic              given_hit,
  output logic              bcast_hit
);
  logic [W-1:0] bcast;

  assign given_hit = ((rx_byte ^ match_value) & match_mask) == '0;
  assign bcast = match_value | match_mask;
  assign bcast_hit = ((rx_byte ^ bcast) & bcast) == '0;

endmodule
`default_nettype wire

// [design/uamp_top.sv]
// Serial receiver with automatic multiprocessor address recognition behind an APB slave.
// Assumes rxd is asynchronous to pclk and the master marks address frames by the ninth bit.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uamp_top #(
  parameter int unsigned BAUD_W = 16
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic [uamp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         rxd,
  output logic                              irq
);

  typedef struct packed {
    uamp_pkg::uamp_rx_e         st;
    logic [1:0]                 rxd_sync;
    logic                       rxd_q;
    logic [BAUD_W-1:0]          div_cnt;
    logic [3:0]                 os_cnt;
    logic [1:0]                 votes;
    logic [3:0]                 bit_cnt;
    logic [8:0]                 shift;
    logic [3:0]                 ctrl;
    logic [7:0]                 match_value;
    logic [7:0]                 match_mask;
    logic [7:0]                 rx_data;
    logic                       rx_ninth_bit;
    logic                       rx_done_flag;
    logic                       frame_err;
    logic [uamp_pkg::IRQ_W-1:0] irq_stat;
    logic [uamp_pkg::IRQ_W-1:0] irq_mask;
    logic [BAUD_W-1:0]          baud_div;
    logic [31:0]                prdata;
    logic                       pslverr;
  } uamp_state_s;

  uamp_state_s r;
  uamp_state_s nxt;

  logic                       os_tick;
  logic                       bit_val;
  logic                       nine_bit;
  logic                       multiproc_enable;
  logic                       rx_enable;
  logic [1:0]                 mode;
  logic [7:0]                 frame_byte;
  logic                       frame_ninth;
  logic                       given_hit;
  logic                       bcast_hit;
  logic                       wr_en;
  logic                       setup;
  logic [uamp_pkg::IDX_W-1:0] idx;
  logic                       mapped;
  logic                       rx_ev;
  logic                       fe_ev;
  logic                       qualify;
  logic                       addr_ok;

  assign rx_enable = r.ctrl[uamp_pkg::CTRL_REN];
  assign multiproc_enable = r.ctrl[uamp_pkg::CTRL_MPE];
  assign mode = r.ctrl[uamp_pkg::CTRL_MODE_HI:uamp_pkg::CTRL_MODE_LO];
  assign nine_bit = mode[1];
  assign os_tick = (r.div_cnt == r.baud_div);
  // Majority of three slices; the third vote is the live synchronised level
  assign bit_val = (r.votes[0] & r.votes[1]) | (r.votes[0] & r.rxd_sync[1]) | (r.votes[1] & r.rxd_sync[1]);

  // Ten-bit frames put data in the top eight bits since only eight shifts happen
  assign frame_byte = nine_bit ? r.shift[7:0] : r.shift[8:1];
  assign frame_ninth = nine_bit ? r.shift[8] : bit_val;

  uamp_addr_match #(
    .W (8)
  ) u_match (
    .rx_byte     (frame_byte),
    .match_value (r.match_value),
    .match_mask  (r.match_mask),
    .given_hit   (given_hit),
    .bcast_hit   (bcast_hit)
  );

  // Ninth bit high marks an address frame; in ten-bit mode it is the stop bit
  assign qualify = !multiproc_enable || frame_ninth;
  assign addr_ok = !multiproc_enable || given_hit || bcast_hit;
  assign rx_ev = (r.st == uamp_pkg::RX_STOP) && os_tick && (r.os_cnt == uamp_pkg::OS_VOTE2)
                 && !r.rx_done_flag && qualify && addr_ok;
  assign fe_ev = (r.st == uamp_pkg::RX_STOP) && os_tick && (r.os_cnt == uamp_pkg::OS_VOTE2) && !bit_val;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign idx = paddr[uamp_pkg::ADDR_W-1:2];
  assign mapped = (paddr[1:0] == 2'h0) &&
                  ((idx == uamp_pkg::IDX_CTRL) || (idx == uamp_pkg::IDX_STATUS) ||
                   (idx == uamp_pkg::IDX_RXDATA) || (idx == uamp_pkg::IDX_BAUD) ||
                   (idx == uamp_pkg::IDX_IRQ_STAT) || (idx == uamp_pkg::IDX_IRQ_MASK) ||
                   (idx == uamp_pkg::IDX_MATCH) || (idx == uamp_pkg::IDX_MASK));

  always_comb begin
    nxt = r;
    nxt.rxd_sync = {r.rxd_sync[0], rxd};
    nxt.rxd_q = r.rxd_sync[1];

    // Receive side
    if (os_tick) begin
      nxt.div_cnt = '0;
    end else begin
      nxt.div_cnt = r.div_cnt + 1'b1;
    end
    unique case (r.st)
      uamp_pkg::RX_IDLE: begin
        // Synchronous mode is not received by this block
        if (rx_enable && (mode != uamp_pkg::MODE_SYNC) && r.rxd_q && !r.rxd_sync[1]) begin
          nxt.st = uamp_pkg::RX_START;
          nxt.os_cnt = '0;
          nxt.div_cnt = '0;
          nxt.bit_cnt = '0;
        end
      end
      uamp_pkg::RX_START, uamp_pkg::RX_BITS, uamp_pkg::RX_STOP: begin
        if (os_tick) begin
          nxt.os_cnt = r.os_cnt + 1'b1;
          if (r.os_cnt == uamp_pkg::OS_VOTE0) begin
            nxt.votes[0] = r.rxd_sync[1];
          end
          if (r.os_cnt == uamp_pkg::OS_VOTE1) begin
            nxt.votes[1] = r.rxd_sync[1];
          end
          if (r.os_cnt == uamp_pkg::OS_VOTE2) begin
            if (r.st == uamp_pkg::RX_START) begin
              nxt.st = bit_val ? uamp_pkg::RX_IDLE : uamp_pkg::RX_BITS;
            end else if (r.st == uamp_pkg::RX_BITS) begin
              nxt.shift = {bit_val, r.shift[8:1]};
              nxt.bit_cnt = r.bit_cnt + 1'b1;
              if (r.bit_cnt == ((nine_bit ? uamp_pkg::BITS_ELEVEN : uamp_pkg::BITS_TEN) - 4'h1)) begin
                nxt.st = uamp_pkg::RX_STOP;
              end
            end else begin
              // Back to edge hunting from the middle of the stop bit
              nxt.st = uamp_pkg::RX_IDLE;
            end
          end
        end
      end
    endcase

    if (rx_ev) begin
      nxt.rx_data = frame_byte;
      nxt.rx_ninth_bit = frame_ninth;
    end

    // Register writes; sticky bits clear on a written one but a same-cycle event wins
    nxt.prdata = r.prdata;
    nxt.pslverr = r.pslverr;
    if (setup) begin
      nxt.pslverr = !mapped;
      nxt.prdata = 32'h0000_0000;
      unique case (1'b1)
        idx == uamp_pkg::IDX_CTRL: nxt.prdata[3:0] = r.ctrl;
        idx == uamp_pkg::IDX_STATUS: nxt.prdata[2:0] = {r.frame_err, r.rx_ninth_bit, r.rx_done_flag};
        idx == uamp_pkg::IDX_RXDATA: nxt.prdata[7:0] = r.rx_data;
        idx == uamp_pkg::IDX_BAUD: nxt.prdata[BAUD_W-1:0] = r.baud_div;
        idx == uamp_pkg::IDX_IRQ_STAT: nxt.prdata[uamp_pkg::IRQ_W-1:0] = r.irq_stat;
        idx == uamp_pkg::IDX_IRQ_MASK: nxt.prdata[uamp_pkg::IRQ_W-1:0] = r.irq_mask;
        idx == uamp_pkg::IDX_MATCH: nxt.prdata[7:0] = r.match_value;
        idx == uamp_pkg::IDX_MASK: nxt.prdata[7:0] = r.match_mask;
        default: nxt.prdata = 32'h0000_0000;
      endcase
      if (!mapped) begin
        nxt.prdata = 32'h0000_0000;
      end
    end
    if (wr_en && mapped) begin
      unique case (1'b1)
        idx == uamp_pkg::IDX_CTRL: nxt.ctrl = pwdata[3:0];
        idx == uamp_pkg::IDX_STATUS: begin
          if (pwdata[uamp_pkg::ST_DONE]) begin
            nxt.rx_done_flag = 1'b0;
          end
          if (pwdata[uamp_pkg::ST_FERR]) begin
            nxt.frame_err = 1'b0;
          end
        end
        idx == uamp_pkg::IDX_BAUD: nxt.baud_div = pwdata[BAUD_W-1:0];
        idx == uamp_pkg::IDX_IRQ_STAT: nxt.irq_stat = r.irq_stat & ~pwdata[uamp_pkg::IRQ_W-1:0];
        idx == uamp_pkg::IDX_IRQ_MASK: nxt.irq_mask = pwdata[uamp_pkg::IRQ_W-1:0];
        idx == uamp_pkg::IDX_MATCH: nxt.match_value = pwdata[7:0];
        idx == uamp_pkg::IDX_MASK: nxt.match_mask = pwdata[7:0];
        default: nxt.ctrl = r.ctrl;
      endcase
    end
    if (rx_ev) begin
      nxt.rx_done_flag = 1'b1;
      nxt.irq_stat[uamp_pkg::IRQ_RX] = 1'b1;
    end
    if (fe_ev) begin
      nxt.frame_err = 1'b1;
      nxt.irq_stat[uamp_pkg::IRQ_FE] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.st <= uamp_pkg::RX_IDLE;
      r.rxd_sync <= 2'h3;
      r.rxd_q <= 1'b1;
      r.div_cnt <= '0;
      r.os_cnt <= 4'h0;
      r.votes <= 2'h0;
      r.bit_cnt <= 4'h0;
      r.shift <= 9'h000;
      r.ctrl <= uamp_pkg::CTRL_RST;
      r.match_value <= uamp_pkg::MATCH_RST;
      r.match_mask <= uamp_pkg::MASK_RST;
      r.rx_data <= 8'h00;
      r.rx_ninth_bit <= 1'b0;
      r.rx_done_flag <= 1'b0;
      r.frame_err <= 1'b0;
      r.irq_stat <= '0;
      r.irq_mask <= '0;
      r.baud_div <= uamp_pkg::BAUD_RST[BAUD_W-1:0];
      r.prdata <= 32'h0000_0000;
      r.pslverr <= 1'b0;
    end else begin
      r <= nxt;
    end
  end

  // Zero-wait slave: read data is registered in the setup cycle
  assign pready = 1'b1;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign irq = |(r.irq_stat & r.irq_mask);

endmodule
`default_nettype wire

// [verification/uamp_properties.sv]
// Port checker for the address-match receiver.
// Assumes it is bound to uamp_top with zero wait states.
`timescale 1ns/1ps
`default_nettype none
module uamp_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] idx;
  logic       rd;
  logic       wr;
  logic       mapped;
  logic [7:0] match_r;
  logic [7:0] mask_r;
  assign idx = paddr[11:2];
  assign rd = psel && !penable && !pwrite;
  assign wr = psel && penable && pwrite && pstrb[0] && paddr[1:0] == 2'h0;
  assign mapped = paddr[1:0] == 2'h0 && (idx <= 10'h005 || idx == uamp_pkg::IDX_MATCH || idx == uamp_pkg::IDX_MASK);
  // Shadow copies follow software writes only, so reset must give 00
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_r <= 8'h00;
      mask_r <= 8'h00;
    end else begin
      if (wr && idx == uamp_pkg::IDX_MATCH) match_r <= pwdata[7:0];
      if (wr && idx == uamp_pkg::IDX_MASK) mask_r <= pwdata[7:0];
    end
  end
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_unmapped_err: assert property (rd && !mapped |=> pslverr && prdata == 32'h0) else $error("unmapped read");
  chk_mapped_ok: assert property (psel && !penable && mapped |=> !pslverr) else $error("mapped access refused");
  chk_match_read: assert property (rd && idx == uamp_pkg::IDX_MATCH |=> prdata == {24'h0, match_r})
    else $error("match value read wrong");
  chk_mask_read: assert property (rd && idx == uamp_pkg::IDX_MASK |=> prdata == {24'h0, mask_r})
    else $error("mask read wrong");
  chk_prdata_hold: assert property (psel && penable |=> $stable(prdata)) else $error("read data moved");
  chk_irq_masked: assert property (wr && idx == uamp_pkg::IDX_IRQ_MASK && pwdata[1:0] == 2'h0 |=> !irq [*2])
    else $error("irq with mask clear");
  // Outputs of the design itself right after release, not the shadow copies
  chk_reset_quiet: assert property ($rose(presetn) |-> prdata == 32'h0 && !pslverr && !irq)
    else $error("outputs not idle after reset");
endmodule
bind uamp_top uamp_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .irq);
`default_nettype wire

// [verification/uamp_line_master.sv]
// Serial line master model driving frames onto rxd.
// Assumes baud 0, so one bit lasts 16 pclk cycles.
`timescale 1ns/1ps
`default_nettype none
module uamp_line_master #(
  parameter int BIT_CYC = 16
) (
  input  wire logic pclk,
  output logic      rxd
);
  initial rxd = 1'h1;
  task automatic drive(input logic v);
    rxd <= v;
    repeat (BIT_CYC) @(posedge pclk);
  endtask
  // Idle line is high; two idle bits let a bad stop bit recover
  task automatic send(input logic [7:0] b, input logic has9, input logic n9, input logic stp);
    @(posedge pclk);
    drive(1'h0);
    for (int i = 0; i < 8; i++) drive(b[i]);
    if (has9) drive(n9);
    drive(stp);
    drive(1'h1);
    drive(1'h1);
  endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the address-match receiver.
// Assumes the line master model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        irq;
  logic [31:0] q;
  logic        e;
  logic [7:0]  m_match = 8'h0;
  logic [7:0]  m_mask = 8'h0;
  logic [7:0]  m_data = 8'h0;
  logic        m_flag = 1'h0;
  logic        m_ninth = 1'h0;
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #2.5 pclk = ~pclk;
  uamp_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .irq(irq));
  uamp_line_master line (.pclk(pclk), .rxd(rxd));
  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic logic hit(input logic [7:0] b);
    logic [7:0] bc;
    bc = m_match | m_mask;
    return (((b ^ m_match) & m_mask) == 8'h0) || (((b ^ bc) & bc) == 8'h0);
  endfunction
  task automatic setmm(input logic [7:0] mv, input logic [7:0] kv);
    m_match = mv;
    m_mask = kv;
    apb(1'h1, uamp_pkg::IDX_MATCH, {24'h0, mv});
    apb(1'h1, uamp_pkg::IDX_MASK, {24'h0, kv});
    apb(1'h0, uamp_pkg::IDX_MATCH, 32'h0);
    check(q, {24'h0, mv});
    apb(1'h0, uamp_pkg::IDX_MASK, 32'h0);
    check(q, {24'h0, kv});
  endtask
  // Control word is mode, multiprocessor enable, receive enable
  task automatic frame(input logic [3:0] c, input logic [7:0] b, input logic n9, input logic stp);
    logic t1;
    logic ok;
    t1 = c[3:2] == uamp_pkg::MODE_TEN;
    ok = c[0] && c[3:2] != uamp_pkg::MODE_SYNC && !m_flag;
    ok = ok && (!c[1] || ((t1 ? stp : n9) && hit(b)));
    apb(1'h1, uamp_pkg::IDX_CTRL, {28'h0, c});
    line.send(b, !t1, n9, stp);
    if (ok) begin
      m_flag = 1'h1;
      m_data = b;
      m_ninth = t1 ? stp : n9;
    end
    apb(1'h0, uamp_pkg::IDX_STATUS, 32'h0);
    check(q[1:0], {m_ninth, m_flag});
    apb(1'h0, uamp_pkg::IDX_RXDATA, 32'h0);
    check(q, {24'h0, m_data});
  endtask
  task automatic clr();
    apb(1'h1, uamp_pkg::IDX_STATUS, 32'h5);
    apb(1'h1, uamp_pkg::IDX_IRQ_STAT, 32'h3);
    m_flag = 1'h0;
    // The clearing write lands on the last edge, so irq is only settled one edge later
    @(posedge pclk);
  endtask
  initial begin
    void'($urandom(27000));
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    setmm(8'h0, 8'h0);
    apb(1'h0, 10'h006, 32'h0);
    check(e, 32'h1);
    check(q, 32'h0);
    $display("Test reset done");
    apb(1'h1, uamp_pkg::IDX_BAUD, 32'h0);
    apb(1'h1, uamp_pkg::IDX_IRQ_MASK, 32'h1);
    frame(4'h5, 8'($urandom), 1'h0, 1'h0);
    check(irq, 32'h1);
    clr();
    check(irq, 32'h0);
    frame(4'h4, 8'h5a, 1'h0, 1'h1);
    frame(4'h1, 8'h3c, 1'h0, 1'h1);
    $display("Test basic done");
    setmm(8'ha4, 8'hfa);
    for (int i = 0; i < 10; i++) begin
      frame(i[0] ? 4'hf : 4'hb, i < 8 ? 8'(32'hff35a3a0 >> (i[2:1] * 8)) : 8'ha0, i != 9, 1'h1);
      clr();
    end
    $display("Test address done");
    repeat (6) begin
      setmm(8'($urandom), 8'($urandom));
      frame(4'hf, 8'($urandom), 1'($urandom), 1'h1);
      clr();
    end
    $display("Test random done");
    frame(4'h7, m_match, 1'h0, 1'h0);
    frame(4'h7, m_match, 1'h0, 1'h1);
    frame(4'h7, 8'hff, 1'h0, 1'h1);
    apb(1'h1, uamp_pkg::IDX_IRQ_MASK, 32'h0);
    @(posedge pclk);
    check(irq, 32'h0);
    clr();
    $display("Test ten bit done");
    complete_run();
  end
endmodule
`default_nettype wire
